//--- design/block_ram_pkg.sv
`default_nettype none

package block_ram_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int WORD_W     = 36;  // 32 data bits plus 4 parity bits
  localparam int DATA_W     = 32;
  localparam int ADDR_W     = 11;  // Word address within one section
  localparam int LANES      = 4;
  localparam int LANE_W     = 8;
  localparam int PARITY_LSB = 32;  // Parity bit of lane 0
  localparam int SLICES     = 2;
  localparam int SECTIONS   = 2;

  // ----------------------------------------------------------------
  // Section codes and pin filtering
  // ----------------------------------------------------------------
  localparam logic SECTION_A  = 1'b0;
  localparam logic SECTION_B  = 1'b1;
  localparam int   SYNC_DEPTH = 3;   // Flip-flops on each clock pin
  localparam int   SYNC_LAST  = 2;   // Index of the third flip-flop
  localparam int   SYNC_MID   = 1;   // Index of the second flip-flop

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic               section_a_write_select;
    logic               section_b_write_select;
    logic [LANES-1:0]   lane_write_enable_n;
    logic [ADDR_W-1:0]  write_addr_in;
    logic [WORD_W-1:0]  write_data;
  } write_req_t;

  typedef struct packed {
    logic               read_section_select;
    logic [ADDR_W-1:0]  read_addr_in;
  } read_req_t;

  // Control state of the whole block
  typedef struct packed {
    logic [SLICES-1:0][SYNC_DEPTH-1:0] wclk_sync;
    logic [SLICES-1:0][SYNC_DEPTH-1:0] rclk_sync;
    logic [SLICES-1:0]                 wclk_level;
    logic [SLICES-1:0]                 rclk_level;
    logic [SLICES-1:0][WORD_W-1:0]     rdata;
  } state_t;

endpackage

`default_nettype wire

//--- design/dual_section_block_ram.sv
`default_nettype none


module dual_section_block_ram
#(
  parameter int ADDR_W = block_ram_pkg::ADDR_W,
  parameter int WORD_W = block_ram_pkg::WORD_W
)
(
  input  wire logic                                                    clk,
  input  wire logic                                                    rst,
  input  wire logic                [block_ram_pkg::SLICES-1:0]         write_clock_in,
  input  wire logic                [block_ram_pkg::SLICES-1:0]         read_clock_in,
  input  wire block_ram_pkg::write_req_t [block_ram_pkg::SLICES-1:0]   write_req,
  input  wire block_ram_pkg::read_req_t  [block_ram_pkg::SLICES-1:0]   read_req,
  output logic [block_ram_pkg::SLICES-1:0][block_ram_pkg::WORD_W-1:0]  read_data
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Bit mask of the lanes whose active-low enable is low
  function automatic logic [block_ram_pkg::WORD_W-1:0] lane_mask
  (
    input logic [block_ram_pkg::LANES-1:0] en_n
  );
    logic [block_ram_pkg::WORD_W-1:0] m;
    m = '0;
    for (int l = 0; l < block_ram_pkg::LANES; l++)
    begin
      m[l*block_ram_pkg::LANE_W +: block_ram_pkg::LANE_W] = {block_ram_pkg::LANE_W{~en_n[l]}};
      m[block_ram_pkg::PARITY_LSB + l] = ~en_n[l];
    end
    return m;
  endfunction

  // New word: enabled lanes from the bus, others kept; parity bits are plain data
  function automatic logic [block_ram_pkg::WORD_W-1:0] merge_word
  (
    input logic [block_ram_pkg::WORD_W-1:0] old_word,
    input logic [block_ram_pkg::WORD_W-1:0] new_word,
    input logic [block_ram_pkg::LANES-1:0]  en_n
  );
    logic [block_ram_pkg::WORD_W-1:0] m;
    m = lane_mask(en_n);
    return (old_word & ~m) | (new_word & m);
  endfunction

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  localparam int DEPTH = 2 ** ADDR_W;

  logic [WORD_W-1:0] mem [block_ram_pkg::SLICES][block_ram_pkg::SECTIONS][DEPTH];

  // Control state and per-slice working signals
  block_ram_pkg::state_t                                   st_reg;
  block_ram_pkg::state_t                                   st_next;
  logic [block_ram_pkg::SLICES-1:0]                        wr_fire;
  logic [block_ram_pkg::SLICES-1:0]                        rd_fire;
  logic [block_ram_pkg::SLICES-1:0][ADDR_W-1:0]            waddr;
  logic [block_ram_pkg::SLICES-1:0][WORD_W-1:0]            merged_a;
  logic [block_ram_pkg::SLICES-1:0][WORD_W-1:0]            merged_b;
  logic [block_ram_pkg::SLICES-1:0][WORD_W-1:0]            old_a;
  logic [block_ram_pkg::SLICES-1:0][WORD_W-1:0]            old_b;
  logic [block_ram_pkg::SLICES-1:0][WORD_W-1:0]            other_a;
  logic [block_ram_pkg::SLICES-1:0][WORD_W-1:0]            rd_word;

  // ----------------------------------------------------------------
  // Edge detection and word selection
  // ----------------------------------------------------------------

  // Filtered rising edges of each slice clock; read word picked by section
  always_comb
  begin
    for (int s = 0; s < block_ram_pkg::SLICES; s++)
    begin
      wr_fire[s] = (st_reg.wclk_sync[s][block_ram_pkg::SYNC_MID] == st_reg.wclk_sync[s][block_ram_pkg::SYNC_LAST])
                   && st_reg.wclk_sync[s][block_ram_pkg::SYNC_LAST] && !st_reg.wclk_level[s];
      rd_fire[s] = (st_reg.rclk_sync[s][block_ram_pkg::SYNC_MID] == st_reg.rclk_sync[s][block_ram_pkg::SYNC_LAST])
                   && st_reg.rclk_sync[s][block_ram_pkg::SYNC_LAST] && !st_reg.rclk_level[s];
      waddr[s]    = write_req[s].write_addr_in;
      old_a[s]    = mem[s][0][waddr[s]];
      old_b[s]    = mem[s][1][waddr[s]];
      other_a[s]  = mem[block_ram_pkg::SLICES-1-s][0][waddr[s]];
      merged_a[s] = merge_word(mem[s][0][waddr[s]], write_req[s].write_data, write_req[s].lane_write_enable_n);
      merged_b[s] = merge_word(mem[s][1][waddr[s]], write_req[s].write_data, write_req[s].lane_write_enable_n);
      if (read_req[s].read_section_select == block_ram_pkg::SECTION_B)
      begin
        rd_word[s] = mem[s][1][read_req[s].read_addr_in];
      end
      else
      begin
        rd_word[s] = mem[s][0][read_req[s].read_addr_in];
      end
    end
  end

  // Next control state: pin filters and read register
  always_comb
  begin
    st_next = st_reg;
    for (int s = 0; s < block_ram_pkg::SLICES; s++)
    begin
      st_next.wclk_sync[s] = {st_reg.wclk_sync[s][block_ram_pkg::SYNC_MID:0], write_clock_in[s]};
      st_next.rclk_sync[s] = {st_reg.rclk_sync[s][block_ram_pkg::SYNC_MID:0], read_clock_in[s]};
      if (st_reg.wclk_sync[s][block_ram_pkg::SYNC_MID] == st_reg.wclk_sync[s][block_ram_pkg::SYNC_LAST])
      begin
        st_next.wclk_level[s] = st_reg.wclk_sync[s][block_ram_pkg::SYNC_LAST];
      end
      if (st_reg.rclk_sync[s][block_ram_pkg::SYNC_MID] == st_reg.rclk_sync[s][block_ram_pkg::SYNC_LAST])
      begin
        st_next.rclk_level[s] = st_reg.rclk_sync[s][block_ram_pkg::SYNC_LAST];
      end
      if (rd_fire[s])
      begin
        st_next.rdata[s] = rd_word[s];
      end
    end
  end

  // Control state register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // Section writes; each slice and section is its own array, untouched by others
  always_ff @(posedge clk)
  begin
    for (int s = 0; s < block_ram_pkg::SLICES; s++)
    begin
      if (wr_fire[s] && write_req[s].section_a_write_select)
      begin
        mem[s][0][waddr[s]] <= merged_a[s];
      end
      if (wr_fire[s] && write_req[s].section_b_write_select)
      begin
        mem[s][1][waddr[s]] <= merged_b[s];
      end
    end
  end

  // Read port straight from the output register
  assign read_data = st_reg.rdata;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // One set of checks per slice
  for (genvar g = 0; g < block_ram_pkg::SLICES; g++)
  begin : g_chk
    chk_read_pipe: assert property (@(posedge clk) disable iff (rst)
      rd_fire[g] |=> read_data[g] == $past(rd_word[g]))
      else $error("read word not registered one cycle after read edge");

    chk_read_hold: assert property (@(posedge clk) disable iff (rst)
      !rd_fire[g] |=> $stable(read_data[g]))
      else $error("read data moved without a read edge");

    chk_write_a_lanes: assert property (@(posedge clk) disable iff (rst)
      (wr_fire[g] && write_req[g].section_a_write_select) |=> mem[g][0][$past(waddr[g])] == $past(merged_a[g]))
      else $error("section A word does not hold merged lanes");

    chk_write_b_lanes: assert property (@(posedge clk) disable iff (rst)
      (wr_fire[g] && write_req[g].section_b_write_select) |=> mem[g][1][$past(waddr[g])] == $past(merged_b[g]))
      else $error("section B word does not hold merged lanes");

    chk_unselected_keep: assert property (@(posedge clk) disable iff (rst)
      (wr_fire[g] && !write_req[g].section_a_write_select) |=> mem[g][0][$past(waddr[g])] == $past(old_a[g]))
      else $error("unselected section A was written");

    chk_unselected_keep_b: assert property (@(posedge clk) disable iff (rst)
      (wr_fire[g] && !write_req[g].section_b_write_select) |=> mem[g][1][$past(waddr[g])] == $past(old_b[g]))
      else $error("unselected section B was written");

    chk_write_on_edge: assert property (@(posedge clk) disable iff (rst)
      wr_fire[g] |=> st_reg.wclk_level[g] && !$past(st_reg.wclk_level[g]))
      else $error("write fired without a filtered rising edge");

    chk_filter_follow: assert property (@(posedge clk) disable iff (rst)
      (st_reg.rclk_sync[g][block_ram_pkg::SYNC_MID] == st_reg.rclk_sync[g][block_ram_pkg::SYNC_LAST])
      |=> st_reg.rclk_level[g] == $past(st_reg.rclk_sync[g][block_ram_pkg::SYNC_LAST]))
      else $error("read clock level did not follow agreeing flip-flops");

    chk_slice_apart: assert property (@(posedge clk) disable iff (rst)
      (wr_fire[g] && !wr_fire[block_ram_pkg::SLICES-1-g])
      |=> mem[block_ram_pkg::SLICES-1-g][0][$past(waddr[g])] == $past(other_a[g]))
      else $error("write on one slice changed the other slice");

    chk_read_spacing: assert property (@(posedge clk) disable iff (rst)
      rd_fire[g] |=> !rd_fire[g] [*2])
      else $error("read edges closer than filter allows");

    chk_write_spacing: assert property (@(posedge clk) disable iff (rst)
      wr_fire[g] |=> !wr_fire[g] [*2])
      else $error("write edges closer than filter allows");
  end

endmodule

`default_nettype wire

//--- tb/fabric_port_model.sv
`default_nettype none

// ------------------------------------------------------------
// Fabric user logic driving both slice ports
// ------------------------------------------------------------
module fabric_port_model
(
  input  wire logic                                   clk,
  output var  logic [1:0]                             write_clock_in,
  output var  logic [1:0]                             read_clock_in,
  output var  block_ram_pkg::write_req_t [1:0]        write_req,
  output var  block_ram_pkg::read_req_t  [1:0]        read_req,
  input  wire logic [1:0][block_ram_pkg::WORD_W-1:0]  read_data
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle pins low, no section selected, all lanes off
  initial
  begin
    write_clock_in = 2'h0;
    read_clock_in  = 2'h0;
    write_req      = {2{1'b0, 1'b0, 4'hf, 11'h000, 36'h0}};
    read_req       = '0;
  end

  // One write: request held well past the fire cycle
  task write_word(input int s, input logic sa, input logic sb, input logic [3:0] len,
                  input logic [10:0] a, input logic [35:0] d);
    begin
      @(posedge clk);
      write_req[s] <= '{sa, sb, len, a, d};
      write_clock_in[s] <= 1'b1;
      repeat (4) @(posedge clk);
      write_clock_in[s] <= 1'b0;
      repeat (2) @(posedge clk);
      write_req[s] <= '{1'b0, 1'b0, 4'hf, ~a, ~d};  // Released lines show noise
      repeat (2) @(posedge clk);
    end
  endtask

  // One read: word sampled once the output register has loaded
  task read_word(input int s, input logic sel, input logic [10:0] a, output logic [35:0] q);
    begin
      @(posedge clk);
      read_req[s] <= '{sel, a};
      read_clock_in[s] <= 1'b1;
      repeat (6) @(posedge clk);
      q = read_data[s];
      read_clock_in[s] <= 1'b0;
      repeat (2) @(posedge clk);
      read_req[s] <= '{~sel, ~a};
      repeat (2) @(posedge clk);
    end
  endtask
endmodule

`default_nettype wire

//--- tb/dual_section_block_ram_test.sv
`default_nettype none

// ------------------------------------------------------------
// Table driven bench
// ------------------------------------------------------------
module dual_section_block_ram_test;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {int s; logic sa; logic sb; logic [3:0] len; logic [10:0] a;
                  logic [35:0] d; logic rs; logic [35:0] x;} row_t;

  logic                                   clk = 1'b0;
  logic                                   rst;
  logic [1:0]                             wck;
  logic [1:0]                             rck;
  block_ram_pkg::write_req_t [1:0]        wreq;
  block_ram_pkg::read_req_t  [1:0]        rreq;
  logic [1:0][block_ram_pkg::WORD_W-1:0]  rdata;
  logic [35:0]                            q;
  int                                     err_count = 0;
  int                                     n_compared = 0;
  row_t                                   rows [11];

  // 50 MHz clock
  always #10 clk = ~clk;

  dual_section_block_ram u_dut (.clk(clk), .rst(rst), .write_clock_in(wck), .read_clock_in(rck),
                                .write_req(wreq), .read_req(rreq), .read_data(rdata));
  fabric_port_model u_fab (.clk(clk), .write_clock_in(wck), .read_clock_in(rck), .write_req(wreq),
                           .read_req(rreq), .read_data(rdata));

  task check_word(input logic [35:0] got, input logic [35:0] exp);
    begin
      n_compared++;
      if (got !== exp)
      begin
        $display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
        err_count++;
      end
    end
  endtask

  task results;
    begin
      $display("compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask

  // Hang guard
  initial
  begin
    #100000;
    err_count++;
    results();
  end

  // Rows, then hand-written cases
  initial
  begin
    rows = '{'{0, 1, 0, 4'h0, 11'h000, 36'h912345678, 0, 36'h912345678},
             '{0, 0, 1, 4'h0, 11'h7ff, 36'h6abcdef01, 1, 36'h6abcdef01},
             '{0, 1, 0, 4'h5, 11'h000, 36'hfffffffff, 0, 36'hbff34ff78},
             '{0, 0, 0, 4'h0, 11'h000, 36'h000000000, 0, 36'hbff34ff78},
             '{0, 1, 0, 4'hf, 11'h000, 36'h000000000, 0, 36'hbff34ff78},
             '{1, 1, 1, 4'h0, 11'h123, 36'h50f0f0f0f, 0, 36'h50f0f0f0f},
             '{1, 0, 0, 4'h0, 11'h123, 36'h000000000, 1, 36'h50f0f0f0f},
             '{1, 0, 1, 4'ha, 11'h123, 36'h000000000, 1, 36'h00f000f00},
             '{1, 1, 0, 4'h0, 11'h000, 36'h000000001, 0, 36'h000000001},
             '{0, 0, 0, 4'h0, 11'h000, 36'h000000000, 0, 36'hbff34ff78},
             '{0, 0, 0, 4'h0, 11'h7ff, 36'h000000000, 1, 36'h6abcdef01}};
    rst = 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i])
    begin
      u_fab.write_word(rows[i].s, rows[i].sa, rows[i].sb, rows[i].len, rows[i].a, rows[i].d);
      u_fab.read_word(rows[i].s, rows[i].rs, rows[i].a, q);
      check_word(q, rows[i].x);
    end
    // Read and write of one word in the same fire cycle
    fork
      u_fab.write_word(0, 1'b1, 1'b0, 4'h0, 11'h000, 36'h0);
      u_fab.read_word(0, block_ram_pkg::SECTION_A, 11'h000, q);
    join
    check_word(q, 36'hbff34ff78);
    repeat (5) @(posedge clk);
    check_word(rdata[0], 36'hbff34ff78);
    u_fab.read_word(0, block_ram_pkg::SECTION_A, 11'h000, q);
    check_word(q, 36'h0);
    // Load a nonzero word so the reset check below can fail
    u_fab.read_word(0, block_ram_pkg::SECTION_B, 11'h7ff, q);
    check_word(q, 36'h6abcdef01);
    // Reset in mid-run clears the output registers
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    check_word(rdata[0], 36'h0);
    check_word(rdata[1], 36'h0);
    rst <= 1'b0;
    // Output stays cleared after release; storage survives the reset
    repeat (2) @(posedge clk);
    check_word(rdata[0], 36'h0);
    u_fab.read_word(0, block_ram_pkg::SECTION_B, 11'h7ff, q);
    check_word(q, 36'h6abcdef01);
    results();
  end
endmodule

`default_nettype wire
